//--- hdl/amc_consts.svh
// constants for the accelerometer mode control block
// assumes inclusion by bare name from design files
`ifndef AMC_CONSTS_SVH
`define AMC_CONSTS_SVH
`define AMC_ADDR_MODE_CFG 8'h16
`define AMC_MODE_CFG_RESET 8'h00
`define AMC_BIT_DRIVE 6
`define AMC_BIT_THREE_WIRE 5
`define AMC_BIT_SELF_TEST 4
`define AMC_RANGE_HI 3
`define AMC_RANGE_LO 2
`define AMC_MODE_HI 1
`define AMC_MODE_LO 0
`define AMC_OSC_HZ 150000
`define AMC_MEAS_SLOW_HZ 125
`define AMC_MEAS_FAST_HZ 250
`define AMC_DETECT_HZ 600
`define AMC_RESP_MS 20
`define AMC_CONV_TICKS 16'h0003
`define AMC_SCALE_8G 8'h10
`define AMC_SCALE_2G 8'h40
`define AMC_SCALE_4G 8'h20
`define AMC_THRESH_LEVELS 8'h7f
`define AMC_PULSE_MAX_HALF_MS 8'hfe
`define AMC_LAT_MAX_MS 8'h96
`define AMC_WIN_MAX_MS 8'hfa
`endif

//--- hdl/amc_pkg.sv
// types for the accelerometer mode control block
// assumes nothing beyond a SystemVerilog compiler
package amc_pkg;
    typedef enum logic [1:0] {
        AMC_STANDBY = 2'b00,
        AMC_MEASURE = 2'b01,
        AMC_PULSE = 2'b11,
        AMC_LEVEL = 2'b10
    } amc_mode_t;
    typedef enum logic [1:0] {
        AMC_PH_OFF = 2'b00,
        AMC_PH_UP = 2'b01,
        AMC_PH_ON = 2'b11,
        AMC_PH_DOWN = 2'b10
    } amc_phase_t;
endpackage

//--- hdl/amc_mode_control.sv
// accelerometer mode control: mode register, rate dividers, ready/overrun, detection timers
// assumes a host serial front end that turns bus traffic into single-cycle register strobes
//
// Contract
// - mode field: 00 standby, 01 measure, 10 level detect, 11 pulse detect
// - standby takes no new samples
// - register reads and writes work in standby
// - range 00 8g/16, 01 2g/64, 10 4g/32 counts per g
// - range change applies while measuring, no standby needed
// - eight-bit mode register resets to zero with documented field layout
// - self-test bit applies Z deflection; settles within 20 ms
// - bandwidth select: 62.5 Hz cleared, 125 Hz set
// - output rate 125 Hz at low bandwidth, 250 Hz at high
// - standby to active completes within 20 ms
// - active to standby completes within 20 ms
// - pulse duration limit 0.5 to 127 ms in 0.5 ms steps
// - latency timer 1 to 150 ms in 1 ms steps
// - second-pulse window 1 to 250 ms in 1 ms steps
// - level and pulse detection evaluate at 600 Hz
// - thresholds resolve 127 count levels
// - sample ready rises after conversion, holds until an axis is read
// - new sample before read sets overrun flag
// - detection inactive in measurement mode
`timescale 1ns/1ps
`include "amc_consts.svh"
module amc_mode_control #(
    parameter int CLK_HZ = 20000000,
    parameter int OSC_HZ = `AMC_OSC_HZ,
    parameter int RESP_CYC = (`AMC_RESP_MS * (CLK_HZ / 1000))
) (
    input wire logic mclk_in, // 20 MHz system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic ce_in, // clock enable, freezes state when low
    input wire logic reg_wr_in, // register write strobe
    input wire logic reg_rd_in, // register read strobe
    input wire logic [7:0] reg_addr_in, // register address
    input wire logic [7:0] reg_wdata_in, // write data
    output logic [7:0] reg_rdata_out, // read data
    input wire logic axis_rd_in, // host read of any axis output register
    input wire logic filter_bandwidth_select_in, // 0: 62.5 Hz, 1: 125 Hz
    input wire logic [7:0] pulse_dur_in, // pulse limit, half-ms units
    input wire logic [7:0] latency_in, // latency, ms
    input wire logic [7:0] window_in, // second-pulse window, ms
    input wire logic [7:0] threshold_in, // detection threshold
    output logic [1:0] mode_out, // active operating mode
    output logic powered_out, // measuring circuitry powered
    output logic [7:0] scale_out, // counts per g of current range
    output logic self_test_start_out, // apply Z deflection
    output logic self_test_settled_out, // self-test response settled
    output logic three_wire_select_out, // serial three-wire select
    output logic drive_option_out, // drive option
    output logic sample_strobe_out, // convert all three axes now
    output logic sample_ready_out, // sample ready pin level
    output logic sample_overrun_out, // overrun flag
    output logic detect_tick_out, // 600 Hz detection evaluation tick
    output logic [7:0] pulse_dur_out, // clamped pulse limit
    output logic [7:0] latency_out, // clamped latency
    output logic [7:0] window_out, // clamped window
    output logic [7:0] threshold_out // clamped threshold
);
    // ==================================================
    // cycle counts
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int SLOW_TICKS = OSC_HZ / `AMC_MEAS_SLOW_HZ;
    localparam int FAST_TICKS = OSC_HZ / `AMC_MEAS_FAST_HZ;
    localparam int DET_TICKS = OSC_HZ / `AMC_DETECT_HZ;

    // shared by all four detection limit registers
    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // ==================================================
    // mode register
    // bit 7 is unused and always reads back as zero
    logic [7:0] mode_cfg_r;
    logic cfg_wr;
    assign cfg_wr = ce_in && reg_wr_in && (reg_addr_in == `AMC_ADDR_MODE_CFG);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_cfg_r <= `AMC_MODE_CFG_RESET;
        end else if (cfg_wr) begin
            mode_cfg_r <= {1'b0, reg_wdata_in[6:0]};
        end
    end

    // reads have no side effects, so the read strobe goes unused
    always_comb begin
        reg_rdata_out = (reg_addr_in == `AMC_ADDR_MODE_CFG) ? mode_cfg_r : 8'h00;
    end

    amc_pkg::amc_mode_t req_mode;
    assign req_mode = amc_pkg::amc_mode_t'(mode_cfg_r[`AMC_MODE_HI:`AMC_MODE_LO]);
    assign self_test_start_out = mode_cfg_r[`AMC_BIT_SELF_TEST];
    assign three_wire_select_out = mode_cfg_r[`AMC_BIT_THREE_WIRE];
    assign drive_option_out = mode_cfg_r[`AMC_BIT_DRIVE];

    // range applies combinationally so it follows writes in any mode
    // reserved code 11 keeps the widest range, never an undefined gain
    always_comb begin
        unique case (mode_cfg_r[`AMC_RANGE_HI:`AMC_RANGE_LO])
            2'b01: scale_out = `AMC_SCALE_2G;
            2'b10: scale_out = `AMC_SCALE_4G;
            default: scale_out = `AMC_SCALE_8G;
        endcase
    end

    // ==================================================
    // oscillator divider
    // the ratio truncates, so derived rates run slightly fast
    // ce_in low stops it too, so every timer stretches with the enable
    logic [15:0] osc_cnt_r;
    logic osc_tick;
    assign osc_tick = (osc_cnt_r == 16'(OSC_DIV - 1));
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_cnt_r <= 16'h0000;
        end else if (ce_in) begin
            osc_cnt_r <= osc_tick ? 16'h0000 : osc_cnt_r + 16'h0001;
        end
    end

    // ==================================================
    // power sequencing, bounded by the response time
    // standby during power-up aborts it; power-down always runs to its bound
    amc_pkg::amc_phase_t phase_r;
    logic [31:0] resp_cnt_r;
    logic [1:0] mode_r;
    logic resp_done;
    assign resp_done = (resp_cnt_r == 32'(RESP_CYC - 1));

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_r <= amc_pkg::AMC_PH_OFF;
            resp_cnt_r <= 32'h0000_0000;
            mode_r <= 2'b00;
        end else if (ce_in) begin
            unique case (phase_r)
                amc_pkg::AMC_PH_OFF: begin
                    resp_cnt_r <= 32'h0000_0000;
                    if (req_mode != amc_pkg::AMC_STANDBY) begin
                        phase_r <= amc_pkg::AMC_PH_UP;
                    end
                end
                amc_pkg::AMC_PH_UP: begin
                    resp_cnt_r <= resp_cnt_r + 32'h0000_0001;
                    if (req_mode == amc_pkg::AMC_STANDBY) begin
                        phase_r <= amc_pkg::AMC_PH_OFF;
                    end else if (resp_done) begin
                        phase_r <= amc_pkg::AMC_PH_ON;
                        mode_r <= req_mode;
                    end
                end
                amc_pkg::AMC_PH_ON: begin
                    resp_cnt_r <= 32'h0000_0000;
                    mode_r <= req_mode; // active-to-active switch is immediate
                    if (req_mode == amc_pkg::AMC_STANDBY) begin
                        phase_r <= amc_pkg::AMC_PH_DOWN;
                        mode_r <= 2'b00; // sampling stops at once
                    end
                end
                amc_pkg::AMC_PH_DOWN: begin
                    resp_cnt_r <= resp_cnt_r + 32'h0000_0001;
                    if (resp_done) begin
                        phase_r <= amc_pkg::AMC_PH_OFF;
                    end
                end
            endcase
        end
    end
    assign mode_out = mode_r;
    assign powered_out = (phase_r != amc_pkg::AMC_PH_OFF);

    // ==================================================
    // sample and detection rates
    // dividers restart after every mode switch, so the first period is full length
    logic [15:0] meas_cnt_r;
    logic [15:0] det_cnt_r;
    logic [15:0] meas_top;
    logic measuring;
    logic detecting;
    logic mode_settled;
    // written and effective mode must agree, so a switch leaks no last strobe or tick
    assign mode_settled = (phase_r == amc_pkg::AMC_PH_ON) && (mode_r == req_mode);
    assign measuring = mode_settled && (mode_r == amc_pkg::AMC_MEASURE);
    assign detecting = mode_settled && mode_r[1];
    assign meas_top = filter_bandwidth_select_in ? 16'(FAST_TICKS - 1) : 16'(SLOW_TICKS - 1);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meas_cnt_r <= 16'h0000;
            sample_strobe_out <= 1'b0;
        end else if (ce_in) begin
            sample_strobe_out <= 1'b0;
            if (!measuring) begin
                meas_cnt_r <= 16'h0000;
            end else if (osc_tick) begin
                if (meas_cnt_r >= meas_top) begin
                    meas_cnt_r <= 16'h0000;
                    sample_strobe_out <= 1'b1;
                end else begin
                    meas_cnt_r <= meas_cnt_r + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            det_cnt_r <= 16'h0000;
            detect_tick_out <= 1'b0;
        end else if (ce_in) begin
            detect_tick_out <= 1'b0;
            if (!detecting) begin
                det_cnt_r <= 16'h0000;
            end else if (osc_tick) begin
                if (det_cnt_r == 16'(DET_TICKS - 1)) begin
                    det_cnt_r <= 16'h0000;
                    detect_tick_out <= 1'b1;
                end else begin
                    det_cnt_r <= det_cnt_r + 16'h0001;
                end
            end
        end
    end

    // ==================================================
    // conversion completes a few oscillator ticks after the strobe
    logic [15:0] conv_cnt_r;
    logic converting_r;
    logic conv_done;
    assign conv_done = converting_r && osc_tick && (conv_cnt_r == `AMC_CONV_TICKS);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_cnt_r <= 16'h0000;
            converting_r <= 1'b0;
        end else if (ce_in) begin
            if (sample_strobe_out) begin
                converting_r <= 1'b1;
                conv_cnt_r <= 16'h0000;
            end else if (conv_done || !measuring) begin
                converting_r <= 1'b0;
            end else if (converting_r && osc_tick) begin
                conv_cnt_r <= conv_cnt_r + 16'h0001;
            end
        end
    end

    // new data wins over a read in the same cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_ready_out <= 1'b0;
            sample_overrun_out <= 1'b0;
        end else if (ce_in) begin
            if (conv_done) begin
                sample_ready_out <= 1'b1;
                if (sample_ready_out && !axis_rd_in) begin
                    sample_overrun_out <= 1'b1;
                end
            end else if (axis_rd_in) begin
                sample_ready_out <= 1'b0;
                sample_overrun_out <= 1'b0;
            end
        end
    end

    // ==================================================
    // self-test settling
    // the deflection itself is analogue; only its settling bound lives here
    logic [31:0] st_cnt_r;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_cnt_r <= 32'h0000_0000;
        end else if (ce_in) begin
            if (!self_test_start_out || !powered_out) begin
                st_cnt_r <= 32'h0000_0000;
            end else if (st_cnt_r != 32'(RESP_CYC)) begin
                st_cnt_r <= st_cnt_r + 32'h0000_0001;
            end
        end
    end
    assign self_test_settled_out = (st_cnt_r == 32'(RESP_CYC));

    // ==================================================
    // detection timing limits, registered
    // out-of-range requests pin to the nearest legal limit; reset gives the smallest
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_dur_out <= 8'h01;
            latency_out <= 8'h01;
            window_out <= 8'h01;
            threshold_out <= 8'h00;
        end else if (ce_in) begin
            pulse_dur_out <= clamp(pulse_dur_in, 8'h01, `AMC_PULSE_MAX_HALF_MS);
            latency_out <= clamp(latency_in, 8'h01, `AMC_LAT_MAX_MS);
            window_out <= clamp(window_in, 8'h01, `AMC_WIN_MAX_MS);
            threshold_out <= clamp(threshold_in, 8'h00, `AMC_THRESH_LEVELS);
        end
    end
endmodule

//--- tb/amc_mode_control_checker.sv
// concurrent checks on the mode control ports
// assumes one clock domain; bound to every instance of the block
`timescale 1ns/1ps
`include "amc_consts.svh"
module amc_mode_control_checker #(
    parameter int RESP_CYC = 400000
) (
    input wire logic mclk_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic ce_in, // enable
    input wire logic reg_wr_in, // write
    input wire logic [7:0] reg_addr_in, // address
    input wire logic [7:0] reg_wdata_in, // data
    input wire logic [7:0] reg_rdata_out, // read data
    input wire logic axis_rd_in, // axis read
    input wire logic [7:0] latency_in, // latency
    input wire logic [1:0] mode_out, // mode
    input wire logic powered_out, // power
    input wire logic [7:0] scale_out, // scale
    input wire logic self_test_start_out, // self-test
    input wire logic self_test_settled_out, // settled
    input wire logic sample_strobe_out, // strobe
    input wire logic sample_ready_out, // ready
    input wire logic sample_overrun_out, // overrun
    input wire logic detect_tick_out, // tick
    input wire logic [7:0] latency_out, // latency
    input wire logic three_wire_select_out, // three-wire bit
    input wire logic drive_option_out, // drive bit
    input wire logic [7:0] pulse_dur_in, // pulse limit in
    input wire logic [7:0] window_in, // window in
    input wire logic [7:0] threshold_in, // threshold in
    input wire logic [7:0] pulse_dur_out, // pulse limit
    input wire logic [7:0] window_out, // window
    input wire logic [7:0] threshold_out // threshold
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    // ==========================================================
    // powered while reporting standby means a transition in either direction
    logic [31:0] trans_cnt_r;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trans_cnt_r <= 32'h0000_0000;
        end else if (!powered_out || mode_out != amc_pkg::AMC_STANDBY) begin
            trans_cnt_r <= 32'h0000_0000;
        end else if (ce_in) begin
            trans_cnt_r <= trans_cnt_r + 32'h0000_0001;
        end
    end
    sequence cfg_wr_s;
        ce_in && reg_wr_in && reg_addr_in == `AMC_ADDR_MODE_CFG;
    endsequence
    sequence wake_wr_s;
        ce_in && reg_wr_in && reg_addr_in == `AMC_ADDR_MODE_CFG && reg_wdata_in[1:0] != 2'b00 && !powered_out;
    endsequence
    reg_write_a: assert property (cfg_wr_s |=> self_test_start_out == $past(reg_wdata_in[4])
        && (reg_addr_in != `AMC_ADDR_MODE_CFG || reg_rdata_out == ($past(reg_wdata_in) & 8'h7f)))
        else $error("register write not taken");
    cfg_bits_a: assert property (cfg_wr_s |=> three_wire_select_out == $past(reg_wdata_in[5])
        && drive_option_out == $past(reg_wdata_in[6])) else $error("option bits not taken");
    scale_map_a: assert property (reg_addr_in == `AMC_ADDR_MODE_CFG |-> scale_out ==
        (reg_rdata_out[3:2] == 2'b01 ? 8'h40 : reg_rdata_out[3:2] == 2'b10 ? 8'h20 : 8'h10)) else $error("bad scale");
    self_bit_a: assert property (reg_addr_in == `AMC_ADDR_MODE_CFG |-> self_test_start_out == reg_rdata_out[4])
        else $error("self-test bit not driven");
    standby_quiet_a: assert property (!powered_out |-> !sample_strobe_out && !detect_tick_out)
        else $error("activity while powered down");
    wake_start_a: assert property (wake_wr_s ##1 ce_in |=> powered_out)
        else $error("no power-up after mode write");
    resp_bound_a: assert property (trans_cnt_r <= RESP_CYC + 2) else $error("mode change too slow");
    meas_nodet_a: assert property (mode_out == amc_pkg::AMC_MEASURE |-> !detect_tick_out)
        else $error("detection active in measurement");
    ready_hold_a: assert property (sample_ready_out && !axis_rd_in && !reg_wr_in
        && mode_out == amc_pkg::AMC_MEASURE |=> sample_ready_out) else $error("ready dropped without read");
    overrun_cause_a: assert property ($rose(sample_overrun_out) |-> $past(sample_ready_out))
        else $error("overrun without unread sample");
    lat_pass_a: assert property ((ce_in && latency_in >= 8'h01 && latency_in <= 8'h96) [*2]
        |-> latency_out == $past(latency_in)) else $error("legal latency altered");
    lat_range_a: assert property (latency_out >= 8'h01 && latency_out <= 8'h96) else $error("latency out of range");
    settle_cause_a: assert property ($rose(self_test_settled_out) |-> self_test_start_out && powered_out)
        else $error("self-test settled without request");
    pulse_clamp_a: assert property (ce_in |=> pulse_dur_out == ($past(pulse_dur_in) == 8'h00 ? 8'h01
        : $past(pulse_dur_in) > 8'hfe ? 8'hfe : $past(pulse_dur_in))) else $error("pulse limit not clamped");
    win_clamp_a: assert property (ce_in |=> window_out == ($past(window_in) == 8'h00 ? 8'h01
        : $past(window_in) > 8'hfa ? 8'hfa : $past(window_in))) else $error("window not clamped");
    thr_clamp_a: assert property (ce_in |=> threshold_out == ($past(threshold_in) > 8'h7f ? 8'h7f
        : $past(threshold_in))) else $error("threshold not clamped");
endmodule
bind amc_mode_control amc_mode_control_checker #(.RESP_CYC(RESP_CYC)) amc_mode_control_checker_i (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .axis_rd_in(axis_rd_in), .latency_in(latency_in),
    .mode_out(mode_out), .powered_out(powered_out), .scale_out(scale_out), .self_test_start_out(self_test_start_out),
    .self_test_settled_out(self_test_settled_out), .sample_strobe_out(sample_strobe_out),
    .sample_ready_out(sample_ready_out), .sample_overrun_out(sample_overrun_out), .detect_tick_out(detect_tick_out),
    .latency_out(latency_out), .three_wire_select_out(three_wire_select_out), .drive_option_out(drive_option_out),
    .pulse_dur_in(pulse_dur_in), .window_in(window_in), .threshold_in(threshold_in), .pulse_dur_out(pulse_dur_out),
    .window_out(window_out), .threshold_out(threshold_out));

//--- tb/amc_host_model.sv
// host controller model: register strobes and axis reads toward the block
// assumes the block samples its strobes on the rising edge of mclk_in
`timescale 1ns/1ps
module amc_host_model #(
    parameter int WAKE_CYC = 20000
) (
    input wire logic mclk_in, // clock
    output logic reg_wr_out = 1'b0, // write strobe
    output logic reg_rd_out = 1'b0, // read strobe
    output logic [7:0] reg_addr_out = 8'h00, // address
    output logic [7:0] reg_wdata_out = 8'h00, // write data
    output logic axis_rd_out = 1'b0 // axis read
);
    int up_cnt = 0;
    always @(posedge mclk_in) begin
        if (up_cnt < WAKE_CYC) up_cnt <= up_cnt + 1;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        while (up_cnt < WAKE_CYC) @(posedge mclk_in);
        @(posedge mclk_in);
        #1;
        reg_wr_out = wr;
        reg_rd_out = ~wr;
        reg_addr_out = a;
        reg_wdata_out = d;
        @(posedge mclk_in);
        #1;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        // released lines show the inverse so a stale value is never trusted
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    task automatic axis_read();
        @(posedge mclk_in);
        #1;
        axis_rd_out = 1'b1;
        @(posedge mclk_in);
        #1;
        axis_rd_out = 1'b0;
    endtask
endmodule

//--- tb/amc_mode_control_tb_top.sv
// self-checking bench: host model in front, queue-based result monitor
// assumes the design, its header and the bound checker are compiled first
`timescale 1ns/1ps
`include "amc_consts.svh"
module amc_mode_control_tb_top;
    // low nominal rate shortens every divided period to at most 15600 cycles
    localparam int CLK_HZ = 2000000;
    localparam int RESP = 50;
    localparam int TICK = CLK_HZ / `AMC_OSC_HZ;
    localparam logic [7:0] ADR = `AMC_ADDR_MODE_CFG;
    logic mclk_in = 1'b0;
    logic rst_n_in, ce_in, reg_wr_in, reg_rd_in, axis_rd_in, fbw, sts, rdy, ovr, stb, tick, want_tick;
    logic [7:0] reg_addr_in, reg_wdata_in, rdata, scale, pdur, lat, win, thr, shadow, rv;
    logic [18:0] exp_q[$];
    int gap_q[$];
    int err_total = 0, num_checks = 0, cyc = 0, last_ev = 0, seed;
    amc_host_model #(.WAKE_CYC(CLK_HZ / 1000)) amc_host_model_i (.mclk_in(mclk_in), .reg_wr_out(reg_wr_in),
        .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .axis_rd_out(axis_rd_in));
    amc_mode_control #(.CLK_HZ(CLK_HZ), .RESP_CYC(RESP)) amc_mode_control_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .ce_in(ce_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .axis_rd_in(axis_rd_in), .filter_bandwidth_select_in(fbw),
        .pulse_dur_in(pdur), .latency_in(lat), .window_in(win), .threshold_in(thr), .mode_out(), .powered_out(),
        .scale_out(scale), .self_test_start_out(), .self_test_settled_out(sts), .three_wire_select_out(),
        .drive_option_out(), .sample_strobe_out(stb), .sample_ready_out(rdy), .sample_overrun_out(ovr),
        .detect_tick_out(tick), .pulse_dur_out(), .latency_out(), .window_out(), .threshold_out());
    initial forever #25 mclk_in = ~mclk_in;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        if (ce_in) shadow = {1'b0, d[6:0]};
        amc_host_model_i.xfer(1'b1, ADR, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic r, input logic o, input logic s);
        logic [7:0] sc;
        sc = (shadow[3:2] == 2'b01) ? 8'h40 : (shadow[3:2] == 2'b10) ? 8'h20 : 8'h10;
        exp_q.push_back({s, r, o, sc, (a == ADR) ? shadow : 8'h00});
        amc_host_model_i.xfer(1'b0, a, 8'h00);
    endtask
    task automatic ev();
        int n;
        n = 0;
        @(posedge mclk_in);
        while ((want_tick ? tick : stb) !== 1'b1) begin
            n++;
            if (n > 16000) begin
                err_total++;
                $display("MISMATCH t=%0t no event", $time);
                tally_and_finish();
            end
            @(posedge mclk_in);
        end
        #1;
    endtask
    task automatic gap(input int g);
        ev();
        gap_q.push_back(g);
        ev();
    endtask
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (reg_rd_in === 1'b1) chk({13'h0000, sts, rdy, ovr, scale, rdata}, 32'(exp_q.pop_front()));
        if ((want_tick ? tick : stb) === 1'b1) begin
            if (gap_q.size() > 0) chk(cyc - last_ev, gap_q.pop_front());
            last_ev <= cyc;
        end
    end
    // about 62000 cycles expected: wake wait, two slow, two fast and four detection periods
    initial begin
        repeat (90000) @(posedge mclk_in);
        err_total++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        seed = $urandom(32'h74b1e5c8);
        rst_n_in = 1'b0;
        ce_in = 1'b1;
        fbw = 1'b0;
        want_tick = 1'b0;
        shadow = 8'h00;
        {pdur, lat, win, thr} = $urandom();
        repeat (4) @(posedge mclk_in);
        #1;
        rst_n_in = 1'b1;
        rd(ADR, 1'b0, 1'b0, 1'b0);
        rd(8'h17, 1'b0, 1'b0, 1'b0);
        for (int r = 0; r < 4; r++) begin
            rv = 8'($urandom());
            wr({rv[7:5], 1'b0, 2'(r), 2'b00});
            rd(ADR, 1'b0, 1'b0, 1'b0);
        end
        ce_in = 1'b0;
        wr(8'h0d);
        ce_in = 1'b1;
        rd(ADR, 1'b0, 1'b0, 1'b0);
        wr(8'h05);
        gap(`AMC_OSC_HZ / `AMC_MEAS_SLOW_HZ * TICK);
        repeat (100) @(posedge mclk_in);
        #1;
        wr(8'h09);
        rd(ADR, 1'b1, 1'b1, 1'b0);
        amc_host_model_i.axis_read();
        rd(ADR, 1'b0, 1'b0, 1'b0);
        wr(8'h19);
        repeat (RESP + 5) @(posedge mclk_in);
        rd(ADR, 1'b0, 1'b0, 1'b1);
        fbw = 1'b1;
        gap(`AMC_OSC_HZ / `AMC_MEAS_FAST_HZ * TICK);
        want_tick = 1'b1;
        for (int m = 2; m < 4; m++) begin
            wr(8'h08);
            repeat (RESP + 5) @(posedge mclk_in);
            #1;
            {pdur, lat, win, thr} = $urandom();
            wr({6'h02, 2'(m)});
            gap(`AMC_OSC_HZ / `AMC_DETECT_HZ * TICK);
        end
        tally_and_finish();
    end
endmodule
